/* sli_pkg.sv */
// Constants and types for the status indicator block
package sli_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned FLASH_ON_MS = 200;
    localparam int unsigned FLASH_GAP_MS = 200;
    localparam int unsigned FLASH_REST_MS = 1000;
    localparam int unsigned BLINK_MS = 200;
    localparam int unsigned GOOD_DARK_MS = 200;
    localparam int unsigned BAD_DARK_MS = 200;
    localparam int unsigned BAD_RED_MS = 200;
    localparam int unsigned MS_CYCLES_INT = CLK_HZ / 1000;
    localparam logic [16:0] MS_CYCLES = 17'(MS_CYCLES_INT);
    localparam int unsigned PATTERN_MS = 2 * FLASH_ON_MS + FLASH_GAP_MS + FLASH_REST_MS;
    localparam logic [10:0] PATTERN_LAST = 11'(PATTERN_MS - 1);
    localparam logic [10:0] SINGLE_OFF_AT = 11'(FLASH_ON_MS);
    localparam logic [10:0] DOUBLE_ON2_AT = 11'(FLASH_ON_MS + FLASH_GAP_MS);
    localparam logic [10:0] DOUBLE_OFF2_AT = 11'(2 * FLASH_ON_MS + FLASH_GAP_MS);
    localparam logic [10:0] BLINK_LEN = 11'(BLINK_MS);
    localparam logic [10:0] SINGLE_LAST = 11'(FLASH_ON_MS + FLASH_REST_MS - 1);
    localparam logic [10:0] BAD_DARK_LEN = 11'(BAD_DARK_MS);
    localparam logic [10:0] BAD_RED_LEN = 11'(BAD_RED_MS);
    localparam logic [10:0] GOOD_DARK_LEN = 11'(GOOD_DARK_MS);
    localparam int unsigned PARAM_WORDS = 16;
    localparam logic [3:0] PARAM_LAST = 4'hf;
    localparam logic [3:0] ADDR_IDX = 4'h0;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    typedef enum logic [1:0] {SLI_SLAVE_INIT, SLI_SLAVE_PREOP, SLI_SLAVE_SAFEOP,
        SLI_SLAVE_OP} sli_slave_t;
    typedef enum {SLI_PRI_INIT, SLI_PRI_GREEN, SLI_PRI_DARK_GOOD, SLI_PRI_DARK_BAD,
        SLI_PRI_RED_BAD} sli_pri_t;
endpackage : sli_pkg

/* sli_flash_gen.sv */
// Free-running millisecond pattern generator for flash codes
`timescale 1ns/100ps
`default_nettype none
module sli_flash_gen
(
    input wire logic i_clk, // System clock
    input wire logic i_srst, // Sync reset
    output logic o_ms_tick, // One-cycle millisecond pulse
    output logic o_blink, // Even 200/200 blink
    output logic o_single, // Single flash
    output logic o_double // Double flash
);
    import sli_pkg::*;
    logic [16:0] div_ff, nxt_div;
    logic [10:0] ms_ff, nxt_ms;
    logic [10:0] sng_ff, nxt_sng;
    logic [10:0] bl_ff, nxt_bl;
    logic bst_ff, nxt_bst;
    logic tick_ff, nxt_tick;
    logic sgl_ff, nxt_sgl;
    logic dbl_ff, nxt_dbl;
    always_comb
    begin
        nxt_div = div_ff + 17'h00001;
        nxt_tick = 1'b0;
        nxt_ms = ms_ff;
        nxt_sng = sng_ff;
        nxt_bl = bl_ff;
        nxt_bst = bst_ff;
        if (div_ff == MS_CYCLES - 17'h00001)
        begin
            nxt_div = 17'h00000;
            nxt_tick = 1'b1;
            nxt_ms = (ms_ff == PATTERN_LAST) ? 11'h000 : ms_ff + 11'h001;
            nxt_sng = (sng_ff == SINGLE_LAST) ? 11'h000 : sng_ff + 11'h001;
            if (bl_ff == BLINK_LEN - 11'h001)
            begin
                nxt_bl = 11'h000;
                nxt_bst = ~bst_ff;
            end
            else
            begin
                nxt_bl = bl_ff + 11'h001;
            end
        end
        // Single: 200 on, 1000 off; double: 200 on, 200 off, 200 on, 1000 off
        nxt_sgl = sng_ff < SINGLE_OFF_AT; // see RULE13
        nxt_dbl = (ms_ff < SINGLE_OFF_AT) ||
            (ms_ff >= DOUBLE_ON2_AT && ms_ff < DOUBLE_OFF2_AT); // see RULE13
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            div_ff <= 17'h00000;
            ms_ff <= 11'h000;
            sng_ff <= 11'h000;
            bl_ff <= 11'h000;
            bst_ff <= 1'b1;
            tick_ff <= 1'b0;
            sgl_ff <= 1'b0;
            dbl_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            ms_ff <= nxt_ms;
            sng_ff <= nxt_sng;
            bl_ff <= nxt_bl;
            bst_ff <= nxt_bst;
            tick_ff <= nxt_tick;
            sgl_ff <= nxt_sgl;
            dbl_ff <= nxt_dbl;
        end
    end
    assign o_ms_tick = tick_ff;
    assign o_blink = bst_ff; // see RULE13
    assign o_single = sgl_ff;
    assign o_double = dbl_ff;
endmodule // sli_flash_gen
`default_nettype wire

/* sli_status_led.sv */
// Power/read and network status indicator logic with parameter store
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: Green blink while initialising, then steady green
// RULE2: Good read: brief dark, back to green
// RULE3: No read: dark, red, then green
// RULE4: Network dark when bus inactive or uninitialised
// RULE5: Pre-operational, config valid: green even blink
// RULE6: Safe-operational single green flash; operational steady
// RULE7: Config fault in pre-operational: red blink
// RULE8: Local error: red single flashes
// RULE9: Any watchdog timeout: red double flashes
// RULE10: Bus error: continuous red
// RULE11: Slave states advance in order on master request
// RULE12: Settings and address kept in hood memory
// RULE13: Flash timings 200 on, 200 gap, 1000 rest
// RULE14: Most severe network condition wins
module sli_status_led
(
    input wire logic i_clk, // System clock
    input wire logic i_srst, // Sync reset
    input wire logic i_init_done, // Initialisation complete
    input wire logic i_dev_fault, // Initialisation fault
    input wire logic i_read_good, // Pulse: decode succeeded
    input wire logic i_read_fail, // Pulse: read gate ended without decode
    input wire logic i_bus_active, // Fieldbus initialised and active
    input wire sli_pkg::sli_slave_t i_state_req, // State requested by master
    input wire logic i_state_req_vld, // Pulse: master state request
    input wire logic i_cfg_fault, // Configuration invalid
    input wire logic i_local_err, // Local error, e.g. sync loss
    input wire logic i_wd_pd, // Process data watchdog expired
    input wire logic i_wd_bus, // Bus watchdog expired
    input wire logic i_wd_sm, // Sync manager watchdog expired
    input wire logic i_bus_err, // Bus error, no master link
    input wire logic i_prm_wr, // Pulse: write parameter word
    input wire logic [3:0] i_prm_idx, // Parameter word index
    input wire logic [15:0] i_prm_wdata, // Parameter write data
    input wire logic i_new_reader, // Pulse: replacement reader fitted
    output logic o_pri_green, // Power/read indicator green
    output logic o_pri_red, // Power/read indicator red
    output logic o_net_green, // Network indicator green
    output logic o_net_red, // Network indicator red
    output sli_pkg::sli_slave_t o_slave_state, // Current slave state
    output logic o_state_rej, // Pulse: out-of-order request refused
    output logic o_xfer_vld, // Pulse per transferred word
    output logic [3:0] o_xfer_idx, // Transferred word index
    output logic [15:0] o_xfer_data, // Transferred word
    output logic [15:0] o_net_addr // Stored network address
);
    import sli_pkg::*;

    // =========================================================
    // Flash pattern source
    logic ms_tick;
    logic pat_blink;
    logic pat_single;
    logic pat_double;
    sli_flash_gen u_flash
    (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .o_ms_tick(ms_tick),
        .o_blink(pat_blink),
        .o_single(pat_single),
        .o_double(pat_double)
    );

    // =========================================================
    // Power/read indicator sequencer
    sli_pri_t pri_ff, nxt_pri;
    logic [10:0] pcnt_ff, nxt_pcnt;
    logic pg_ff, nxt_pg;
    logic pr_ff, nxt_pr;
    always_comb
    begin
        nxt_pri = pri_ff;
        nxt_pcnt = ms_tick ? pcnt_ff + 11'h001 : pcnt_ff;
        unique case (pri_ff)
            SLI_PRI_INIT:
            begin
                if (i_init_done && !i_dev_fault)
                begin
                    nxt_pri = SLI_PRI_GREEN; // see RULE1
                end
            end
            SLI_PRI_GREEN:
            begin
                nxt_pcnt = 11'h000;
                if (i_read_fail)
                begin
                    nxt_pri = SLI_PRI_DARK_BAD; // see RULE3
                end
                else if (i_read_good)
                begin
                    nxt_pri = SLI_PRI_DARK_GOOD; // see RULE2
                end
            end
            SLI_PRI_DARK_GOOD:
            begin
                if (pcnt_ff >= GOOD_DARK_LEN)
                begin
                    nxt_pri = SLI_PRI_GREEN; // see RULE2
                end
            end
            SLI_PRI_DARK_BAD:
            begin
                if (pcnt_ff >= BAD_DARK_LEN)
                begin
                    nxt_pri = SLI_PRI_RED_BAD; // see RULE3
                    nxt_pcnt = 11'h000;
                end
            end
            SLI_PRI_RED_BAD:
            begin
                if (pcnt_ff >= BAD_RED_LEN)
                begin
                    nxt_pri = SLI_PRI_GREEN; // see RULE3
                end
            end
        endcase
        nxt_pg = (nxt_pri == SLI_PRI_GREEN) ||
            (nxt_pri == SLI_PRI_INIT && pat_blink); // see RULE1
        nxt_pr = nxt_pri == SLI_PRI_RED_BAD; // see RULE3
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pri_ff <= SLI_PRI_INIT;
            pcnt_ff <= 11'h000;
            pg_ff <= 1'b0;
            pr_ff <= 1'b0;
        end
        else
        begin
            pri_ff <= nxt_pri;
            pcnt_ff <= nxt_pcnt;
            pg_ff <= nxt_pg;
            pr_ff <= nxt_pr;
        end
    end
    assign o_pri_green = pg_ff;
    assign o_pri_red = pr_ff;

    // =========================================================
    // Slave state tracking
    sli_slave_t st_ff, nxt_st;
    logic rej_ff, nxt_rej;
    always_comb
    begin
        nxt_st = st_ff;
        nxt_rej = 1'b0;
        if (!i_bus_active)
        begin
            nxt_st = SLI_SLAVE_INIT;
        end
        else if (i_state_req_vld)
        begin
            // Steps up only one at a time; falling back is always allowed
            if (i_state_req <= st_ff || i_state_req == sli_slave_t'(st_ff + 2'h1))
            begin
                nxt_st = i_state_req; // see RULE11
            end
            else
            begin
                nxt_rej = 1'b1; // see RULE11
            end
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            st_ff <= SLI_SLAVE_INIT;
            rej_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            rej_ff <= nxt_rej;
        end
    end
    assign o_slave_state = st_ff;
    assign o_state_rej = rej_ff;

    // =========================================================
    // Network indicator with severity priority
    logic ng_ff, nxt_ng;
    logic nr_ff, nxt_nr;
    always_comb
    begin
        nxt_ng = 1'b0;
        nxt_nr = 1'b0;
        if (!i_bus_active)
        begin
            nxt_ng = 1'b0; // see RULE4
        end
        else if (i_bus_err)
        begin
            nxt_nr = 1'b1; // see RULE10 RULE14
        end
        else if (i_wd_pd || i_wd_bus || i_wd_sm)
        begin
            nxt_nr = pat_double; // see RULE9 RULE14
        end
        else if (i_local_err)
        begin
            nxt_nr = pat_single; // see RULE8 RULE14
        end
        else if (i_cfg_fault && st_ff == SLI_SLAVE_PREOP)
        begin
            nxt_nr = pat_blink; // see RULE7 RULE14
        end
        else
        begin
            unique case (st_ff)
                SLI_SLAVE_INIT: nxt_ng = 1'b0; // see RULE4
                SLI_SLAVE_PREOP: nxt_ng = pat_blink; // see RULE5
                SLI_SLAVE_SAFEOP: nxt_ng = pat_single; // see RULE6
                SLI_SLAVE_OP: nxt_ng = 1'b1; // see RULE6
            endcase
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ng_ff <= 1'b0;
            nr_ff <= 1'b0;
        end
        else
        begin
            ng_ff <= nxt_ng;
            nr_ff <= nxt_nr;
        end
    end
    assign o_net_green = ng_ff;
    assign o_net_red = nr_ff;

    // =========================================================
    // Hood parameter memory and replacement transfer
    logic [15:0] prm_mem [PARAM_WORDS];
    logic xact_ff, nxt_xact;
    logic [3:0] xidx_ff, nxt_xidx;
    logic xv_ff, nxt_xv;
    logic [3:0] xoi_ff, nxt_xoi;
    logic [15:0] xd_ff, nxt_xd;
    always_ff @(posedge i_clk)
    begin
        if (i_prm_wr)
        begin
            prm_mem[i_prm_idx] <= i_prm_wdata; // see RULE12
        end
    end
    always_comb
    begin
        nxt_xact = xact_ff;
        nxt_xidx = xidx_ff;
        nxt_xv = 1'b0;
        nxt_xoi = xoi_ff;
        nxt_xd = xd_ff;
        if (xact_ff)
        begin
            nxt_xv = 1'b1; // see RULE12
            nxt_xoi = xidx_ff;
            nxt_xd = prm_mem[xidx_ff];
            nxt_xidx = xidx_ff + 4'h1;
            nxt_xact = xidx_ff != PARAM_LAST;
        end
        else if (i_new_reader)
        begin
            nxt_xact = 1'b1;
            nxt_xidx = 4'h0;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            xact_ff <= 1'b0;
            xidx_ff <= 4'h0;
            xv_ff <= 1'b0;
            xoi_ff <= 4'h0;
            xd_ff <= 16'h0000;
        end
        else
        begin
            xact_ff <= nxt_xact;
            xidx_ff <= nxt_xidx;
            xv_ff <= nxt_xv;
            xoi_ff <= nxt_xoi;
            xd_ff <= nxt_xd;
        end
    end
    logic [15:0] addr_ff;
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            addr_ff <= ADDR_RESET;
        end
        else if (i_prm_wr && i_prm_idx == ADDR_IDX)
        begin
            addr_ff <= i_prm_wdata; // see RULE12
        end
    end
    assign o_xfer_vld = xv_ff;
    assign o_xfer_idx = xoi_ff;
    assign o_xfer_data = xd_ff;
    assign o_net_addr = addr_ff;
endmodule // sli_status_led
`default_nettype wire

/* sli_status_led_sva.sv */
// Port checks for the status indicator block
`timescale 1ns/100ps
`default_nettype none
module sli_status_led_sva
(
    input wire logic i_clk, // Clock
    input wire logic i_srst, // Reset
    input wire logic i_bus_active, // Bus up
    input wire logic i_bus_err, // Bus error
    input wire sli_pkg::sli_slave_t i_state_req, // Request
    input wire logic i_state_req_vld, // Request strobe
    input wire logic i_cfg_fault, // Bad config
    input wire logic i_local_err, // Local error
    input wire logic i_wd_pd, // Watchdog
    input wire logic i_wd_bus, // Watchdog
    input wire logic i_wd_sm, // Watchdog
    input wire logic i_prm_wr, // Param write
    input wire logic [3:0] i_prm_idx, // Param index
    input wire logic [15:0] i_prm_wdata, // Param data
    input wire logic o_net_green, // Net green
    input wire logic o_net_red, // Net red
    input wire sli_pkg::sli_slave_t o_slave_state, // Slave state
    input wire logic o_state_rej, // Refusal
    input wire logic o_xfer_vld, // Transfer strobe
    input wire logic [3:0] o_xfer_idx, // Transfer index
    input wire logic [15:0] o_net_addr // Address
);
    import sli_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    a_net_dark: assert property (!i_bus_active |=> !o_net_green && !o_net_red)
        else $error("net indicator lit while bus inactive");
    a_bus_err_red: assert property (i_bus_active && i_bus_err |=> o_net_red && !o_net_green)
        else $error("bus error not steady red");
    a_fault_no_green: assert property (i_bus_active && (i_wd_pd || i_wd_bus || i_wd_sm
        || i_local_err || (i_cfg_fault && o_slave_state == SLI_SLAVE_PREOP)) |=> !o_net_green)
        else $error("net green during fault");
    a_op_green: assert property (i_bus_active && !i_bus_err && !i_wd_pd && !i_wd_bus
        && !i_wd_sm && !i_local_err && !i_state_req_vld && o_slave_state == SLI_SLAVE_OP
        |=> o_net_green && !o_net_red)
        else $error("operational not steady green");
    a_skip_refused: assert property (i_state_req_vld && i_bus_active
        && {1'b0, i_state_req} > {1'b0, o_slave_state} + 3'd1 |=> o_state_rej && $stable(o_slave_state))
        else $error("skip-ahead request not refused");
    a_step_taken: assert property (i_state_req_vld && i_bus_active
        && {1'b0, i_state_req} <= {1'b0, o_slave_state} + 3'd1
        |=> !o_state_rej && o_slave_state == $past(i_state_req))
        else $error("state request not taken");
    a_xfer_first: assert property ($rose(o_xfer_vld) |-> o_xfer_idx == 4'h0)
        else $error("transfer does not start at word zero");
    a_xfer_step: assert property (o_xfer_vld && o_xfer_idx != 4'hf
        |=> o_xfer_vld && o_xfer_idx == $past(o_xfer_idx) + 4'h1)
        else $error("transfer burst broken");
    a_addr_word: assert property (i_prm_wr && i_prm_idx == ADDR_IDX
        |=> o_net_addr == $past(i_prm_wdata))
        else $error("address not taken from word zero");
endmodule // sli_status_led_sva
bind sli_status_led sli_status_led_sva u_sva (
    .i_clk(i_clk), .i_srst(i_srst), .i_bus_active(i_bus_active), .i_bus_err(i_bus_err),
    .i_state_req(i_state_req), .i_state_req_vld(i_state_req_vld), .i_cfg_fault(i_cfg_fault),
    .i_local_err(i_local_err), .i_wd_pd(i_wd_pd), .i_wd_bus(i_wd_bus), .i_wd_sm(i_wd_sm),
    .i_prm_wr(i_prm_wr), .i_prm_idx(i_prm_idx), .i_prm_wdata(i_prm_wdata),
    .o_net_green(o_net_green), .o_net_red(o_net_red), .o_slave_state(o_slave_state),
    .o_state_rej(o_state_rej), .o_xfer_vld(o_xfer_vld), .o_xfer_idx(o_xfer_idx),
    .o_net_addr(o_net_addr)
);
`default_nettype wire

/* sli_master_model.sv */
// Fieldbus master model issuing slave state requests
`timescale 1ns/100ps
`default_nettype none
module sli_master_model
(
    input wire logic i_clk, // Clock
    output var sli_pkg::sli_slave_t o_state_req, // Requested state
    output var logic o_state_req_vld // Request strobe
);
    import sli_pkg::*;
    initial
    begin
        o_state_req = SLI_SLAVE_INIT;
        o_state_req_vld = 1'b0;
    end
    // One request held over one edge, value scrambled once released
    task automatic request(input sli_slave_t s);
        o_state_req = s;
        o_state_req_vld = 1'b1;
        @(posedge i_clk);
        #1;
        o_state_req_vld = 1'b0;
        o_state_req = sli_slave_t'(~s);
    endtask
endmodule // sli_master_model
`default_nettype wire

/* sli_status_led_tb.sv */
// Self-checking bench for the status indicator block
`timescale 1ns/100ps
`default_nettype none
module sli_status_led_tb;
    import sli_pkg::*;
    logic i_clk, i_srst, init_done, dev_fault, read_good, read_fail, bus_active, cfg_fault;
    logic local_err, wd_pd, wd_bus, wd_sm, bus_err, prm_wr, new_reader, state_req_vld;
    logic pri_g, pri_r, net_g, net_r, state_rej, xfer_vld;
    logic [3:0] prm_idx, xfer_idx;
    logic [15:0] prm_wdata, xfer_data, net_addr;
    sli_slave_t state_req, slave_state;
    int fails, checks, n;
    sli_master_model u_master (.i_clk(i_clk), .o_state_req(state_req),
        .o_state_req_vld(state_req_vld));
    sli_status_led u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_init_done(init_done),
        .i_dev_fault(dev_fault), .i_read_good(read_good), .i_read_fail(read_fail),
        .i_bus_active(bus_active), .i_state_req(state_req), .i_state_req_vld(state_req_vld),
        .i_cfg_fault(cfg_fault), .i_local_err(local_err), .i_wd_pd(wd_pd), .i_wd_bus(wd_bus),
        .i_wd_sm(wd_sm), .i_bus_err(bus_err), .i_prm_wr(prm_wr), .i_prm_idx(prm_idx),
        .i_prm_wdata(prm_wdata), .i_new_reader(new_reader), .o_pri_green(pri_g),
        .o_pri_red(pri_r), .o_net_green(net_g), .o_net_red(net_r), .o_slave_state(slave_state),
        .o_state_rej(state_rej), .o_xfer_vld(xfer_vld), .o_xfer_idx(xfer_idx),
        .o_xfer_data(xfer_data), .o_net_addr(net_addr));
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // ==========================================
    // Compare and timing tasks
    task automatic chk_b(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic network_state_indicator(input logic g, input logic r);
        chk_b(net_g, g);
        chk_b(net_r, r);
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        fails = 0;
        checks = 0;
        i_srst = 1'b1;
        {init_done, dev_fault, read_good, read_fail, bus_active, cfg_fault} = 6'h00;
        {local_err, wd_pd, wd_bus, wd_sm, bus_err, prm_wr, new_reader} = 7'h00;
        prm_idx = 4'h0;
        prm_wdata = 16'h0000;
        step(6);
        i_srst = 1'b0;
        chk_b(pri_g, 1'b0);
        chk_w(16'(slave_state), 16'h0000);
        chk_w(net_addr, 16'h0000);
        step(2);
        chk_b(pri_g, 1'b1);
        network_state_indicator(1'b0, 1'b0);
        {read_good, read_fail, dev_fault, init_done} = 4'hf;
        step(1);
        {read_good, read_fail} = 2'h0;
        step(2);
        chk_b(pri_g, 1'b1);
        dev_fault = 1'b0;
        step(2);
        chk_b(pri_g, 1'b1);
        read_good = 1'b1;
        step(1);
        read_good = 1'b0;
        step(1);
        chk_b(pri_g, 1'b0);
        chk_b(pri_r, 1'b0);
        bus_active = 1'b1;
        step(2);
        network_state_indicator(1'b0, 1'b0);
        u_master.request(SLI_SLAVE_PREOP);
        step(2);
        network_state_indicator(1'b1, 1'b0);
        cfg_fault = 1'b1;
        step(2);
        network_state_indicator(1'b0, 1'b1);
        cfg_fault = 1'b0;
        u_master.request(SLI_SLAVE_OP);
        chk_b(state_rej, 1'b1);
        chk_w(16'(slave_state), 16'h0001);
        step(1);
        u_master.request(SLI_SLAVE_SAFEOP);
        step(2);
        network_state_indicator(1'b1, 1'b0);
        u_master.request(SLI_SLAVE_OP);
        step(2);
        network_state_indicator(1'b1, 1'b0);
        local_err = 1'b1;
        step(2);
        network_state_indicator(1'b0, 1'b1);
        for (n = 0; n < 3; n++)
        begin
            {wd_sm, wd_bus, wd_pd} = 3'b001 << n;
            step(2);
            network_state_indicator(1'b0, 1'b1);
        end
        bus_err = 1'b1;
        step(2);
        network_state_indicator(1'b0, 1'b1);
        bus_active = 1'b0;
        step(2);
        network_state_indicator(1'b0, 1'b0);
        chk_w(16'(slave_state), 16'h0000);
        {local_err, wd_pd, wd_bus, wd_sm, bus_err} = 5'h00;
        // Second reset, then a failed read from steady green
        i_srst = 1'b1;
        step(2);
        i_srst = 1'b0;
        chk_b(pri_g, 1'b0);
        chk_w(net_addr, 16'h0000);
        step(1);
        chk_b(pri_g, 1'b1);
        {read_good, read_fail} = 2'h3;
        step(1);
        {read_good, read_fail} = 2'h0;
        step(1);
        chk_b(pri_g, 1'b0);
        chk_b(pri_r, 1'b0);
        prm_wr = 1'b1;
        for (n = 0; n < 16; n++)
        begin
            prm_idx = 4'(n);
            prm_wdata = 16'ha5c0 ^ 16'(n);
            step(1);
        end
        prm_wr = 1'b0;
        step(1);
        chk_w(net_addr, 16'ha5c0);
        new_reader = 1'b1;
        step(1);
        new_reader = 1'b0;
        for (n = 0; n < 8 && xfer_vld !== 1'b1; n++)
            step(1);
        if (n == 8)
        begin
            fails++;
            $display("[ERR] %0t transfer never started", $time);
        end
        else
        begin
            for (n = 0; n < 16; n++)
            begin
                chk_w(16'(xfer_idx), 16'(n));
                chk_w(xfer_data, 16'ha5c0 ^ 16'(n));
                step(1);
            end
            chk_b(xfer_vld, 1'b0);
        end
        final_report;
    end
endmodule // sli_status_led_tb
`default_nettype wire
